// file: hw/whae_pkg.sv
// shared constants and types for the wayside heat and auxiliary alarm block
package whae_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb side)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;   // enables, clearance
  localparam logic [ADDR_W-1:0] OFF_LIMIT = 12'h004;  // hot-wheel offset
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008; // integrity, state
  localparam logic [ADDR_W-1:0] OFF_COUNTS = 12'h00c; // recorded counts
  localparam logic [ADDR_W-1:0] OFF_HEAT = 12'h010;   // last axle peak

  // ----------------------------------------------------------------
  // control register fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_HW_EN = 0;    // hot-wheel detection enable
  localparam int CTRL_DRAG_EN = 1;  // dragging-equipment enable
  localparam int CTRL_HL_EN = 2;    // high-load enable
  localparam int CTRL_WL_EN = 3;    // wide-load enable
  localparam int CTRL_BEAM = 4;     // 1 light beam, 0 trip wire
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam int HEAT_W = 8;
  localparam logic [HEAT_W-1:0] LIMIT_RST = 8'h64;

  // status register fields
  localparam int STAT_HL_FAIL = 0;  // stuck high-load before train
  localparam int STAT_WL_FAIL = 1;  // stuck wide-load before train
  localparam int STAT_OPEN = 2;     // gate window open now

  // ----------------------------------------------------------------
  // per-train limits and contact inputs
  // ----------------------------------------------------------------
  localparam int SAMPLES_PER_AXLE = 48;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] HW_ANN_MAX = 8'h04;
  localparam logic [CNT_W-1:0] DRAG_ANN_MAX = 8'h02;
  localparam logic [CNT_W-1:0] CLR_ANN_MAX = 8'h02;
  localparam int AUX_N = 4;
  localparam int AUX_DRAG = 0;
  localparam int AUX_HL = 1;
  localparam int AUX_WL_A = 2;
  localparam int AUX_WL_B = 3;

  // ----------------------------------------------------------------
  // gate timing, in clock cycles at 50 MHz
  // ----------------------------------------------------------------
  localparam int TIME_W = 24;
  // 24 in gate at about 60 mph is roughly 22.7 ms
  localparam logic [TIME_W-1:0] DEF_ON_CYC = 24'h1157ac;
  // speed bands of the linearity table (on time thresholds)
  localparam logic [TIME_W-1:0] LIN_T_FAST = 24'h0c3500;
  localparam logic [TIME_W-1:0] LIN_T_MID = 24'h249f00;
  localparam logic [TIME_W-1:0] LIN_T_SLOW = 24'h7a1200;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hot_wheel;
    logic drag;
    logic high_load;
    logic wide_load;
  } whae_alarm_s;

  typedef enum logic [1:0] {WHAE_IDLE, WHAE_OPEN, WHAE_EVAL} whae_state_e;

endpackage

// file: hw/whae_lin_corr.sv
// linearity correction of one heat sample by speed band and heat band
`timescale 1ns/1ps
module whae_lin_corr #(
  parameter int HW = whae_pkg::HEAT_W,
  parameter int TW = whae_pkg::TIME_W
) (
  // raw sample and speed reference
  input wire logic [HW-1:0] raw,
  input wire logic [TW-1:0] on_time,
  // corrected sample
  output logic [HW-1:0] corrected
);
  import whae_pkg::*;

  // gain in sixteenths; rows by speed band, columns by heat band
  // the pyrometer droops at both speed ends, so the outer rows lift
  localparam logic [4:0] GAIN [16] = '{
    5'h13, 5'h12, 5'h11, 5'h11,   // fastest axles
    5'h10, 5'h10, 5'h10, 5'h10,   // linear range
    5'h10, 5'h10, 5'h10, 5'h10,   // linear range
    5'h12, 5'h11, 5'h11, 5'h10    // slowest axles
  };

  logic [1:0] speed_band;         // 0 fast .. 3 slow
  logic [3:0] idx;                // table index
  logic [HW+4:0] prod;            // raw times gain
  logic [HW:0] scaled;            // back to heat units plus carry

  // speed band from the axle on time
  always_comb begin
    if (on_time < LIN_T_FAST) begin
      speed_band = 2'h0;
    end else if (on_time < LIN_T_MID) begin
      speed_band = 2'h1;
    end else if (on_time < LIN_T_SLOW) begin
      speed_band = 2'h2;
    end else begin
      speed_band = 2'h3;
    end
  end

  // lookup and scale; saturate rather than wrap a hot reading
  always_comb begin
    idx = {speed_band, raw[HW-1:HW-2]};
    prod = raw * GAIN[idx];
    scaled = prod[HW+4:4];
    corrected = scaled[HW] ? {HW{1'b1}} : scaled[HW-1:0];
  end

endmodule

// file: hw/whae_top.sv
// per-axle hot-wheel and auxiliary alarm evaluation with apb registers
`timescale 1ns/1ps
// What this block does
// - sample heat 48 times per axle, keep peak
// - peak is degrees above ambient for comparisons
// - correct samples by on time and heat
// - wheel sampling uses the bearing gate window
// - hot wheel when enabled and above offset
// - record all hot wheels, announce first four
// - four aux inputs, open contact means alarm
// - dragging: record all, announce first two
// - high load when enabled and contact open
// - trip wire: one high-load alarm per train
// - light beam: no high load on consecutive axles
// - announce at most two high-load alarms
// - stuck high-load pretrain: fail, disable, no axle
// - wide load is OR of two sides
// - trip wire: one wide-load alarm per train
// - light beam: wide load spaced, announce two
// - stuck wide-load pretrain: fail, disable, no axle
// - one clearance setting for high and wide
// - falling gate edge marks wheel centred
module whae_top #(
  parameter logic [whae_pkg::TIME_W-1:0] DEF_ON = whae_pkg::DEF_ON_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [whae_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // track pins (asynchronous)
  input wire logic gate_a,
  input wire logic gate_b,
  input wire logic [whae_pkg::AUX_N-1:0] contact_closed,
  // converter and train logic (same clock)
  input wire logic [whae_pkg::HEAT_W-1:0] heat_raw,
  input wire logic train_start,
  // per-axle results
  output logic scan_window,
  output logic axle_done,
  output whae_pkg::whae_alarm_s rec_alarm,
  output whae_pkg::whae_alarm_s ann_alarm,
  output logic [whae_pkg::HEAT_W-1:0] axle_heat,
  output logic hl_integrity_fail,
  output logic wl_integrity_fail
);
  import whae_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // register select, shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CTRL: reg_sel = 3'h1;
      OFF_LIMIT: reg_sel = 3'h2;
      OFF_STATUS: reg_sel = 3'h3;
      OFF_COUNTS: reg_sel = 3'h4;
      OFF_HEAT: reg_sel = 3'h5;
      default: reg_sel = 3'h0;
    endcase
  endfunction

  // saturating count step, counts never wrap to zero
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    sat_inc = (c == {CNT_W{1'b1}}) ? c : c + 8'h01;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;            // enables and clearance type
  logic [HEAT_W-1:0] limit;           // hot-wheel offset above ambient
  logic [5:0] pin_s1;                 // first synchroniser stage
  logic [5:0] pin_s2;                 // second synchroniser stage
  logic [5:0] pin_q;                  // previous stage-two value
  whae_state_e state;                 // axle window state
  logic first_b;                      // window opened on gate b
  logic [TIME_W-1:0] on_time;         // cycles in current window
  logic [TIME_W-1:0] ref_time;        // last axle on time
  logic [TIME_W:0] acc;               // sample phase accumulator
  logic [5:0] nsamp;                  // samples taken this axle
  logic [HEAT_W-1:0] peak;            // largest corrected sample
  logic [AUX_N-1:0] aux_seen;         // open contacts this axle
  logic [CNT_W-1:0] hw_cnt;           // recorded counts this train
  logic [CNT_W-1:0] drag_cnt;
  logic [CNT_W-1:0] hl_cnt;
  logic [CNT_W-1:0] wl_cnt;
  logic hl_prev;                      // previous axle flagged high
  logic wl_prev;                      // previous axle flagged wide

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  logic [1:0] gate_s;                 // synchronised gates
  logic [AUX_N-1:0] contact_s;        // synchronised contacts
  logic [AUX_N-1:0] contact_open;     // alarm indication per input
  logic fall_a;
  logic fall_b;
  logic close_edge;                   // far gate centred
  logic take;                         // sample strobe
  logic [HEAT_W-1:0] corr;            // corrected sample
  logic apb_wr;
  logic apb_setup;
  whae_alarm_s next_rec;
  whae_alarm_s next_ann;

  assign gate_s = pin_s2[1:0];
  assign contact_s = pin_s2[5:2];
  assign contact_open = ~contact_s;
  assign fall_a = pin_q[0] & ~gate_s[0];
  assign fall_b = pin_q[1] & ~gate_s[1];
  assign close_edge = first_b ? fall_a : fall_b;
  assign apb_setup = psel & ~penable;
  assign apb_wr = psel & penable & pready & pwrite;

  // half-inch strobe: 48 steps per last on time spread the samples
  // evenly at any speed; the first axle uses the default on time
  assign take = (state == WHAE_OPEN) && (acc >= {1'b0, ref_time}) &&
                (nsamp < 6'(SAMPLES_PER_AXLE));

  // real-time correction keyed by speed reference and raw heat
  whae_lin_corr #(
    .HW(HEAT_W),
    .TW(TIME_W)
  ) u_lin (
    .raw(heat_raw),
    .on_time(ref_time),
    .corrected(corr)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------

  // two stages before any logic, third stage only for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_q <= 6'h00;
    end else begin
      pin_s1 <= {contact_closed, gate_b, gate_a};
      pin_s2 <= pin_s1;
      pin_q <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // axle window
  // ----------------------------------------------------------------

  // window opens on one gate's falling edge, closes on the other's
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= WHAE_IDLE;
      first_b <= 1'b0;
    end else begin
      case (state)
        WHAE_IDLE: begin
          if (fall_a || fall_b) begin
            state <= WHAE_OPEN;
            first_b <= fall_b & ~fall_a;
          end
        end
        WHAE_OPEN: begin
          if (close_edge) begin
            state <= WHAE_EVAL;
          end
        end
        WHAE_EVAL: begin
          state <= WHAE_IDLE;
        end
        default: begin
          state <= WHAE_IDLE;
        end
      endcase
    end
  end

  // window to the outside for bearing sampling; registered, it opens one cycle after the wheel window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_window <= 1'b0;
    end else begin
      scan_window <= (state == WHAE_OPEN) && !close_edge;
    end
  end

  // on time count and speed reference for the next axle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_time <= '0;
      ref_time <= DEF_ON;
    end else if (state == WHAE_IDLE) begin
      on_time <= '0;
    end else if (state == WHAE_OPEN) begin
      if (on_time != {TIME_W{1'b1}}) begin
        on_time <= on_time + 24'h000001;
      end
    end else if (on_time != '0) begin
      ref_time <= on_time;
    end
  end

  // sample spacing and peak hold of corrected heat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= '0;
      nsamp <= 6'h00;
      peak <= '0;
    end else if (state != WHAE_OPEN) begin
      acc <= '0;
      nsamp <= 6'h00;
      peak <= '0;
    end else if (take) begin
      acc <= acc - {1'b0, ref_time} + 25'(SAMPLES_PER_AXLE);
      nsamp <= nsamp + 6'h01;
      if (corr > peak) begin
        peak <= corr;
      end
    end else begin
      acc <= acc + 25'(SAMPLES_PER_AXLE);
    end
  end

  // open contacts seen while the axle is in the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_seen <= '0;
    end else if (state == WHAE_IDLE) begin
      aux_seen <= '0;
    end else if (state == WHAE_OPEN) begin
      aux_seen <= aux_seen | contact_open;
    end
  end

  // ----------------------------------------------------------------
  // alarm qualification
  // ----------------------------------------------------------------

  // decisions for the axle being closed
  always_comb begin
    next_rec.hot_wheel = ctrl[CTRL_HW_EN] && (peak > limit);
    next_rec.drag = ctrl[CTRL_DRAG_EN] && aux_seen[AUX_DRAG];
    // stuck detector blocks every axle of the train
    next_rec.high_load = ctrl[CTRL_HL_EN] && aux_seen[AUX_HL] &&
                         !hl_integrity_fail &&
                         (ctrl[CTRL_BEAM] ? !hl_prev
                                          : (hl_cnt == '0));
    next_rec.wide_load = ctrl[CTRL_WL_EN] &&
                         (aux_seen[AUX_WL_A] || aux_seen[AUX_WL_B]) &&
                         !wl_integrity_fail &&
                         (ctrl[CTRL_BEAM] ? !wl_prev
                                          : (wl_cnt == '0));
    // announce only the earliest ones of each type
    next_ann.hot_wheel = next_rec.hot_wheel && (hw_cnt < HW_ANN_MAX);
    next_ann.drag = next_rec.drag && (drag_cnt < DRAG_ANN_MAX);
    next_ann.high_load = next_rec.high_load &&
                         (hl_cnt < CLR_ANN_MAX);
    next_ann.wide_load = next_rec.wide_load &&
                         (wl_cnt < CLR_ANN_MAX);
  end

  // per-axle result outputs, one pulse per closed window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axle_done <= 1'b0;
      rec_alarm <= '0;
      ann_alarm <= '0;
      axle_heat <= '0;
    end else if (state == WHAE_EVAL) begin
      axle_done <= 1'b1;
      rec_alarm <= next_rec;
      ann_alarm <= next_ann;
      axle_heat <= peak;
    end else begin
      axle_done <= 1'b0;
      rec_alarm <= '0;
      ann_alarm <= '0;
    end
  end

  // recorded counts per train; these also drive the announce limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_cnt <= '0;
      drag_cnt <= '0;
      hl_cnt <= '0;
      wl_cnt <= '0;
    end else if (train_start) begin
      hw_cnt <= '0;
      drag_cnt <= '0;
      hl_cnt <= '0;
      wl_cnt <= '0;
    end else if (state == WHAE_EVAL) begin
      if (next_rec.hot_wheel) begin
        hw_cnt <= sat_inc(hw_cnt);
      end
      if (next_rec.drag) begin
        drag_cnt <= sat_inc(drag_cnt);
      end
      if (next_rec.high_load) begin
        hl_cnt <= sat_inc(hl_cnt);
      end
      if (next_rec.wide_load) begin
        wl_cnt <= sat_inc(wl_cnt);
      end
    end
  end

  // consecutive-axle memory for light-beam spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_prev <= 1'b0;
      wl_prev <= 1'b0;
    end else if (train_start) begin
      hl_prev <= 1'b0;
      wl_prev <= 1'b0;
    end else if (state == WHAE_EVAL) begin
      hl_prev <= next_rec.high_load;
      wl_prev <= next_rec.wide_load;
    end
  end

  // pretrain check: a contact already open when the train starts
  // is a stuck detector; its load alarm stays off until the next train
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hl_integrity_fail <= 1'b0;
      wl_integrity_fail <= 1'b0;
    end else if (train_start) begin
      hl_integrity_fail <= ctrl[CTRL_HL_EN] &&
                           contact_open[AUX_HL];
      wl_integrity_fail <= ctrl[CTRL_WL_EN] &&
                           (contact_open[AUX_WL_A] ||
                            contact_open[AUX_WL_B]);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------

  // no wait state: answer prepared in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready <= 1'b1;
      pslverr <= (reg_sel(paddr) == 3'h0);
      case (reg_sel(paddr))
        3'h1: prdata <= {27'h0, ctrl};
        3'h2: prdata <= {24'h0, limit};
        3'h3: prdata <= {29'h0, state == WHAE_OPEN,
                         wl_integrity_fail, hl_integrity_fail};
        3'h4: prdata <= {wl_cnt, hl_cnt, drag_cnt, hw_cnt};
        3'h5: prdata <= {24'h0, axle_heat};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      // read data drops with the transfer's end
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // writable configuration; other offsets are read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      limit <= LIMIT_RST;
    end else if (apb_wr) begin
      if (reg_sel(paddr) == 3'h1) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end
      if (reg_sel(paddr) == 3'h2) begin
        limit <= pwdata[HEAT_W-1:0];
      end
    end
  end

endmodule

// file: dv/whae_chk.sv
// assertion checker for the alarm evaluation block, bound to its top
`timescale 1ns/1ps
module whae_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // train control
  input wire logic train_start,
  // per-axle results
  input wire logic scan_window,
  input wire logic axle_done,
  input wire whae_pkg::whae_alarm_s rec_alarm,
  input wire whae_pkg::whae_alarm_s ann_alarm,
  input wire logic hl_integrity_fail,
  input wire logic wl_integrity_fail
);
  import whae_pkg::*;
  // ----------------------------------------------------------------
  // per-train recorded counts and last-axle memory
  // ----------------------------------------------------------------
  logic [2:0] n_hw, n_dr, n_hl, n_wl; // recorded so far, saturating
  logic p_hl, p_wl; // last axle flagged
  // train start wins over an axle in the same cycle, as the design does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {n_hw, n_dr, n_hl, n_wl, p_hl, p_wl} <= '0;
    end else if (train_start) begin
      {n_hw, n_dr, n_hl, n_wl, p_hl, p_wl} <= '0;
    end else if (axle_done) begin
      n_hw <= n_hw + {2'b00, rec_alarm.hot_wheel & ~&n_hw};
      n_dr <= n_dr + {2'b00, rec_alarm.drag & ~&n_dr};
      n_hl <= n_hl + {2'b00, rec_alarm.high_load & ~&n_hl};
      n_wl <= n_wl + {2'b00, rec_alarm.wide_load & ~&n_wl};
      p_hl <= rec_alarm.high_load;
      p_wl <= rec_alarm.wide_load;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_DONE_PULSE: assert property (axle_done |=> !axle_done)
    else $error("axle done held past one cycle");
  AST_IDLE_ZERO: assert property (!axle_done |-> !rec_alarm && !ann_alarm)
    else $error("alarm flags outside axle done");
  AST_WIN_CLOSE: assert property ($fell(scan_window) |=> axle_done)
    else $error("no axle result after window close");
  AST_HW_ANN: assert property (axle_done |-> ann_alarm.hot_wheel ==
    (rec_alarm.hot_wheel && n_hw < 3'd4)) else $error("hot wheel cap");
  AST_DR_ANN: assert property (axle_done |-> ann_alarm.drag ==
    (rec_alarm.drag && n_dr < 3'd2)) else $error("dragging cap");
  AST_HL_ANN: assert property (axle_done |-> ann_alarm.high_load ==
    (rec_alarm.high_load && n_hl < 3'd2)) else $error("high load cap");
  AST_WL_ANN: assert property (axle_done |-> ann_alarm.wide_load ==
    (rec_alarm.wide_load && n_wl < 3'd2)) else $error("wide load cap");
  AST_HL_SPACED: assert property (axle_done && p_hl |-> !rec_alarm.high_load)
    else $error("high load on consecutive axles");
  AST_WL_SPACED: assert property (axle_done && p_wl |-> !rec_alarm.wide_load)
    else $error("wide load on consecutive axles");
  AST_HL_FAIL: assert property (hl_integrity_fail |-> !rec_alarm.high_load)
    else $error("high load flagged with stuck detector");
  AST_WL_FAIL: assert property (wl_integrity_fail |-> !rec_alarm.wide_load)
    else $error("wide load flagged with stuck detector");
  AST_FAIL_HOLD: assert property ($changed({hl_integrity_fail,
    wl_integrity_fail}) |-> $past(train_start) || $past(train_start, 2))
    else $error("integrity flag moved inside a train");
  // main scenarios reached
  cover property (axle_done && ann_alarm.hot_wheel);
  cover property (axle_done && p_hl && !rec_alarm.high_load);
  cover property ($rose(hl_integrity_fail));
endmodule
bind whae_top whae_chk u_chk (.pclk(pclk), .presetn(presetn),
  .train_start(train_start), .scan_window(scan_window),
  .axle_done(axle_done), .rec_alarm(rec_alarm), .ann_alarm(ann_alarm),
  .hl_integrity_fail(hl_integrity_fail),
  .wl_integrity_fail(wl_integrity_fail));

// file: dv/whae_track.sv
// track model: gating transducers, heat converter and relay contacts
`timescale 1ns/1ps
module whae_track (
  // clock
  input wire logic pclk,
  // track pins toward the block
  output logic gate_a,
  output logic gate_b,
  output logic [whae_pkg::AUX_N-1:0] contact_closed,
  output logic [whae_pkg::HEAT_W-1:0] heat_raw
);
  import whae_pkg::*;
  // idle track: gates low, every contact closed
  initial begin
    gate_a = 1'b0;
    gate_b = 1'b0;
    contact_closed = 4'hf;
    heat_raw = 8'h00;
  end
  // contacts forced before a train, to fake a stuck detector
  task automatic hold(input logic [3:0] opn);
    contact_closed <= ~opn;
  endtask
  // one wheel through the gate; peak held for several samples
  task automatic axle(input logic [7:0] pk, input logic [3:0] opn);
    gate_a <= 1'b1;
    repeat (40) @(posedge pclk);
    gate_a <= 1'b0;
    contact_closed <= ~opn;
    for (int i = 0; i < 440; i++) begin
      @(posedge pclk);
      // low noise outside the peak
      heat_raw <= (i >= 200 && i < 260) ? pk : 8'($urandom_range(3));
      gate_b <= (i >= 400);
    end
    @(posedge pclk);
    gate_b <= 1'b0;
    contact_closed <= 4'hf;
    repeat (20) @(posedge pclk);
  endtask
endmodule

// file: dv/whae_top_tb.sv
// self-checking bench: registers, trains of axles, alarm caps and spacing
`timescale 1ns/1ps
module whae_top_tb;
  import whae_pkg::*;
  // ----------------------------------------------------------------
  // drive and observe
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic train_start = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, gate_a, gate_b, scan_window, axle_done, eb;
  logic hl_integrity_fail, wl_integrity_fail, hot, fhl, fwl, p_hl, p_wl;
  logic [AUX_N-1:0] contact_closed;
  logic [HEAT_W-1:0] heat_raw, axle_heat;
  logic [3:0] opn, er, ea;
  logic [4:0] c;
  logic [7:0] n [4]; // expected recorded counts
  whae_alarm_s rec_alarm, ann_alarm, got_r, got_a;
  int miscompares = 0;
  int checks = 0;
  int ndone = 0;
  // trains: control word, contacts open at train start
  logic [4:0] tc [6] = '{5'h0f, 5'h1f, 5'h1f, 5'h1f, 5'h0f, 5'h00};
  logic [3:0] ts [6] = '{4'h0, 4'h0, 4'h6, 4'h0, 4'h2, 4'hf};
  always #10 pclk = ~pclk;
  // short gate reference so the first axle samples every 10 cycles
  whae_top #(.DEF_ON(24'd480)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gate_a(gate_a), .gate_b(gate_b), .contact_closed(contact_closed),
    .heat_raw(heat_raw), .train_start(train_start),
    .scan_window(scan_window), .axle_done(axle_done),
    .rec_alarm(rec_alarm), .ann_alarm(ann_alarm), .axle_heat(axle_heat),
    .hl_integrity_fail(hl_integrity_fail),
    .wl_integrity_fail(wl_integrity_fail));
  whae_track trk (.pclk(pclk), .gate_a(gate_a), .gate_b(gate_b),
    .contact_closed(contact_closed), .heat_raw(heat_raw));
  // catch each result in the one cycle it stands
  always @(posedge pclk) begin
    if (axle_done === 1'b1) begin
      got_r <= rec_alarm;
      got_a <= ann_alarm;
      ndone <= ndone + 1;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] ad,
    input logic [31:0] wd, output logic [31:0] rdv, output logic erv);
    int t = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) miscompares++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(82034));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0, rd, eb);
    chk(rd, {27'h0, CTRL_RST});
    apb(1'b0, OFF_LIMIT, 32'h0, rd, eb);
    chk(rd, {24'h0, LIMIT_RST});
    apb(1'b0, 12'h100, 32'h0, rd, eb); // unmapped: error, no data
    chk({rd[30:0], eb}, 32'h1);
    apb(1'b1, OFF_STATUS, 32'hffffffff, rd, eb); // read-only, ignored
    apb(1'b0, OFF_STATUS, 32'h0, rd, eb);
    chk(rd, 32'h0);
    apb(1'b1, OFF_LIMIT, 32'h20, rd, eb);
    for (int t = 0; t < 6; t++) begin
      c = tc[t];
      apb(1'b1, OFF_CTRL, {27'h0, c}, rd, eb);
      trk.hold(ts[t]);
      repeat (5) @(posedge pclk);
      train_start <= 1'b1;
      @(posedge pclk);
      train_start <= 1'b0;
      repeat (5) @(posedge pclk);
      trk.hold(4'h0);
      fhl = c[CTRL_HL_EN] & ts[t][AUX_HL];
      fwl = c[CTRL_WL_EN] & (ts[t][AUX_WL_A] | ts[t][AUX_WL_B]);
      chk(32'({hl_integrity_fail, wl_integrity_fail}), 32'({fhl, fwl}));
      n = '{default: 8'h00};
      {p_hl, p_wl} = 2'b00;
      for (int k = 0; k < 6; k++) begin
        // first two trains: all hot, all open
        hot = (t < 2) | 1'($urandom_range(1));
        opn = (t < 2) ? 4'hf : 4'($urandom_range(15));
        trk.axle(hot ? 8'hff : 8'h00, opn);
        er[3] = c[CTRL_HW_EN] & hot;
        er[2] = c[CTRL_DRAG_EN] & opn[AUX_DRAG];
        er[1] = c[CTRL_HL_EN] & ~fhl & opn[AUX_HL]
          & (c[CTRL_BEAM] ? ~p_hl : n[2] == 8'h00);
        er[0] = c[CTRL_WL_EN] & ~fwl & (opn[AUX_WL_A] | opn[AUX_WL_B])
          & (c[CTRL_BEAM] ? ~p_wl : n[3] == 8'h00);
        for (int i = 0; i < 4; i++) begin
          ea[3-i] = er[3-i] && n[i] < ((i == 0) ? HW_ANN_MAX :
            (i == 1) ? DRAG_ANN_MAX : CLR_ANN_MAX);
          n[i] = n[i] + {7'h0, er[3-i]};
        end
        {p_hl, p_wl} = er[1:0];
        chk(32'(ndone), 32'(6 * t + k + 1));
        chk(32'(got_r), 32'(er));
        chk(32'(got_a), 32'(ea));
        chk(32'(axle_heat > 8'h20), 32'(hot));
      end
      apb(1'b0, OFF_COUNTS, 32'h0, rd, eb);
      chk(rd, {n[3], n[2], n[1], n[0]});
    end
    results();
  end
  // hang guard: about twice the expected run
  initial begin
    #(700_000);
    miscompares++;
    results();
  end
endmodule
